// ===== src/ppp_port.sv
// Device side of the high-voltage parallel programming port.
// Assumes programming mode is already entered; all pins are asynchronous
// to ref_clk and are synchronised before use. Strobes act on their edges.
//
// Functional notes
// R1: address action with byte_select_a high loads upper address
// R2: program strobe commits loaded flash page, busy meanwhile
// R3: programmer repeats page sequence for whole flash
// R4: command 00h clears page write state
// R5: EEPROM command 11h, address, data, page latch fill
// R6: program strobe with byte_select_a low writes EEPROM page
// R7: read command 02h outputs flash low byte
// R8: byte_select_a high switches read to high byte
// R9: read command 03h outputs addressed EEPROM byte
// R10: fuse command 40h writes low fuse, 0 programs
// R11: byte selects 1/0 write the high fuse byte
// R12: byte selects 0/1 write the extended fuse byte
// R13: lock command 20h, zero bits program lock
// R14: lock mode 3 blocks boot lock bit programming
// R15: lock bits cleared only by chip erase
// R16: command 04h reads fuses or lock by selects
// R17: command 08h, address 0 to 2, reads ID
// R18: ID command, address 0, byte_select_a high: calibration
// R19: action select: address, data, command, idle
// R20: ready_busy_flag low while programming, high when ready
// R21: drive data bus only while read_drive_n low
// R22: command and address retained between operations
// R23: programmer keeps read_drive_n high when driving bus
`timescale 1ns/10ps
module ppp_port
	import ppp_pkg::*;
#(
	parameter int FLASH_AW = 8,
	parameter int FLASH_PW = 4,
	parameter int EE_AW    = 6,
	parameter int EE_PW    = 2,
	parameter longint unsigned FLASH_CYCLES  = ppp_pkg::CYC_FLASH,
	parameter longint unsigned EEPROM_CYCLES = ppp_pkg::CYC_EEPROM,
	parameter longint unsigned ERASE_CYCLES  = ppp_pkg::CYC_ERASE,
	parameter longint unsigned FUSE_CYCLES   = ppp_pkg::CYC_FUSE,
	parameter logic [7:0] ID_BYTE0 = 8'h5A, // arbitrary identification value
	parameter logic [7:0] ID_BYTE1 = 8'hA5, // arbitrary identification value
	parameter logic [7:0] ID_BYTE2 = 8'h3C, // arbitrary identification value
	parameter logic [7:0] CAL_BYTE = 8'h80  // arbitrary calibration value
) (
	// Clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// Programmer strobes and selects
	input  wire logic       load_strobe,
	input  wire logic       action_select_hi,
	input  wire logic       action_select_lo,
	input  wire logic       byte_select_a,
	input  wire logic       byte_select_b,
	input  wire logic       page_latch_strobe,
	input  wire logic       program_strobe_n,
	input  wire logic       read_drive_n,
	// Two-way data bus
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	// Status
	output logic            ready_busy_flag,
	output logic      [7:0] fuse_low,
	output logic      [7:0] fuse_high,
	output logic      [7:0] fuse_ext,
	output logic      [7:0] lock_bits
);
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s;
	logic [7:0]       s_data;
	logic             s_load, s_latch, s_prog_n, s_read_n, s_bsa, s_bsb;
	logic [1:0]       s_act;
	logic [1:0]       s_sel;

	// Every pin passes two flops before any decode looks at it
	assign pin_raw = {load_strobe, action_select_hi, action_select_lo, byte_select_a,
		byte_select_b, page_latch_strobe, program_strobe_n, read_drive_n, data_in};

	ppp_sync #(
		.W       (PIN_W),
		.RST_VAL (PIN_IDLE)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.pin_raw  (pin_raw),
		.pin_sync (pin_s)
	);

	assign s_data   = pin_s[PIN_DATA +: 8];
	assign s_load   = pin_s[PIN_LOAD];
	assign s_latch  = pin_s[PIN_LATCH];
	assign s_prog_n = pin_s[PIN_PROG_N];
	assign s_read_n = pin_s[PIN_READ_N];
	assign s_bsa    = pin_s[PIN_BSA];
	assign s_bsb    = pin_s[PIN_BSB];
	assign s_act    = {pin_s[PIN_ACT_HI], pin_s[PIN_ACT_LO]};
	assign s_sel    = {s_bsb, s_bsa};

	// Edge detect on the strobes
	logic load_q_ff, latch_q_ff, prog_q_ff;
	logic nxt_load_q, nxt_latch_q, nxt_prog_q;
	logic load_rise, latch_rise, prog_fall;

	always_comb begin
		nxt_load_q  = clk_en ? s_load : load_q_ff;
		nxt_latch_q = clk_en ? s_latch : latch_q_ff;
		nxt_prog_q  = clk_en ? s_prog_n : prog_q_ff;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			load_q_ff  <= 1'b0;
			latch_q_ff <= 1'b0;
			prog_q_ff  <= 1'b1;
		end else begin
			load_q_ff  <= nxt_load_q;
			latch_q_ff <= nxt_latch_q;
			prog_q_ff  <= nxt_prog_q;
		end
	end

	assign load_rise  = clk_en && s_load && !load_q_ff;
	assign latch_rise = clk_en && s_latch && !latch_q_ff;
	assign prog_fall  = clk_en && !s_prog_n && prog_q_ff;

	// Operation state
	ppp_state_type     state_ff, nxt_state;
	logic [BUSY_W-1:0] busy_cnt_ff, nxt_busy_cnt;
	logic              ready;

	assign ready = (state_ff == PPP_READY);

	// Load registers; strobes while busy are ignored so the running
	// operation keeps the address and data it started with
	logic [7:0] cmd_ff, addr_hi_ff, addr_lo_ff, data_lo_ff, data_hi_ff;
	logic [7:0] nxt_cmd, nxt_addr_hi, nxt_addr_lo, nxt_data_lo, nxt_data_hi;
	logic       page_loaded_ff, nxt_page_loaded;
	logic       flash_buf_we, ee_buf_we;
	logic       flash_commit, ee_commit, chip_erase, fuse_write, lock_write;

	always_comb begin
		nxt_cmd         = cmd_ff;     // Kept until a new command, see R22
		nxt_addr_hi     = addr_hi_ff; // see R22
		nxt_addr_lo     = addr_lo_ff;
		nxt_data_lo     = data_lo_ff;
		nxt_data_hi     = data_hi_ff;
		nxt_page_loaded = page_loaded_ff;
		if (load_rise && ready) begin
			case (s_act) // see R19
				ACT_ADDR: begin
					if (s_bsa) begin
						nxt_addr_hi = s_data; // see R1
					end else begin
						nxt_addr_lo = s_data;
					end
				end
				ACT_DATA: begin
					if (s_bsa) begin
						nxt_data_hi = s_data;
					end else begin
						nxt_data_lo = s_data;
					end
				end
				ACT_CMD: begin
					nxt_cmd = s_data;
					if (s_data == CMD_NOP) begin
						nxt_page_loaded = 1'b0; // Write state reset, see R4
					end
				end
				ACT_IDLE: begin
					nxt_cmd = cmd_ff;
				end
				default: begin
					nxt_cmd = cmd_ff;
				end
			endcase
		end
		if (flash_buf_we || ee_buf_we) begin
			nxt_page_loaded = 1'b1;
		end
		if (flash_commit || ee_commit || chip_erase) begin
			nxt_page_loaded = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_ff         <= CMD_NOP;
			addr_hi_ff     <= 8'h00;
			addr_lo_ff     <= 8'h00;
			data_lo_ff     <= ERASED_BYTE;
			data_hi_ff     <= ERASED_BYTE;
			page_loaded_ff <= 1'b0;
		end else begin
			cmd_ff         <= nxt_cmd;
			addr_hi_ff     <= nxt_addr_hi;
			addr_lo_ff     <= nxt_addr_lo;
			data_lo_ff     <= nxt_data_lo;
			data_hi_ff     <= nxt_data_hi;
			page_loaded_ff <= nxt_page_loaded;
		end
	end

	// Write requests decoded from the latch and program strobes
	logic [15:0] addr_full;
	assign addr_full = {addr_hi_ff, addr_lo_ff};

	assign flash_buf_we = latch_rise && ready && cmd_ff == CMD_WR_FLASH;
	assign ee_buf_we    = latch_rise && ready && cmd_ff == CMD_WR_EEPROM; // see R5
	assign flash_commit = prog_fall && ready && cmd_ff == CMD_WR_FLASH
		&& page_loaded_ff;                                               // see R2
	assign ee_commit    = prog_fall && ready && cmd_ff == CMD_WR_EEPROM
		&& page_loaded_ff && !s_bsa;                                     // see R6
	assign chip_erase   = prog_fall && ready && cmd_ff == CMD_CHIP_ERASE;
	assign fuse_write   = prog_fall && ready && cmd_ff == CMD_WR_FUSE
		&& s_sel != SEL_FUSE_HI;
	assign lock_write   = prog_fall && ready && cmd_ff == CMD_WR_LOCK;

	// Flash array, one page per high address window
	logic [15:0] flash_rd;

	ppp_page_mem #(
		.DW (16),
		.AW (FLASH_AW),
		.PW (FLASH_PW)
	) u_flash (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.clk_en      (clk_en),
		.buf_we      (flash_buf_we),
		.buf_idx     (addr_full[FLASH_PW-1:0]),
		.buf_data    ({data_hi_ff, data_lo_ff}),
		.commit      (flash_commit),
		.commit_page (addr_full[FLASH_AW-1:FLASH_PW]), // see R3
		.erase       (chip_erase),
		.rd_addr     (addr_full[FLASH_AW-1:0]),
		.rd_data     (flash_rd)
	);

	// EEPROM array; it is erased together with the flash
	logic [7:0] ee_rd;

	ppp_page_mem #(
		.DW (8),
		.AW (EE_AW),
		.PW (EE_PW)
	) u_eeprom (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.clk_en      (clk_en),
		.buf_we      (ee_buf_we),
		.buf_idx     (addr_full[EE_PW-1:0]),
		.buf_data    (data_lo_ff),
		.commit      (ee_commit),
		.commit_page (addr_full[EE_AW-1:EE_PW]),
		.erase       (chip_erase),
		.rd_addr     (addr_full[EE_AW-1:0]),
		.rd_data     (ee_rd)
	);

	// Fuse and lock bytes plus the busy timer
	logic [7:0] fuse_lo_ff, fuse_hi_ff, fuse_ext_ff, lock_ff;
	logic [7:0] nxt_fuse_lo, nxt_fuse_hi, nxt_fuse_ext, nxt_lock;
	logic [7:0] lock_keep;
	logic       lock_mode3;

	// Basic lock bits both programmed (zero) freeze the boot lock bits
	assign lock_mode3 = (lock_ff & LOCK_BASIC_MASK) == 8'h00;
	assign lock_keep  = LOCK_UNUSED | (lock_mode3 ? LOCK_BOOT_MASK : 8'h00); // see R14

	always_comb begin
		nxt_fuse_lo  = fuse_lo_ff;
		nxt_fuse_hi  = fuse_hi_ff;
		nxt_fuse_ext = fuse_ext_ff;
		nxt_lock     = lock_ff;
		nxt_state    = state_ff;
		nxt_busy_cnt = busy_cnt_ff;
		if (fuse_write) begin
			case (s_sel)
				SEL_FUSE_LO:  nxt_fuse_lo  = data_lo_ff; // see R10
				SEL_LOCK:     nxt_fuse_hi  = data_lo_ff; // Selects 1/0, see R11
				SEL_FUSE_EXT: nxt_fuse_ext = data_lo_ff; // see R12
				default:      nxt_fuse_lo  = fuse_lo_ff;
			endcase
		end
		// A lock write can only clear bits; ones come back through erase only
		if (lock_write) begin
			nxt_lock = lock_ff & (data_lo_ff | lock_keep); // see R13 R15
		end
		if (chip_erase) begin
			nxt_lock = LOCK_RST; // see R15
		end
		case (state_ff) // see R20
			PPP_READY: begin
				if (flash_commit) begin
					nxt_state    = PPP_BUSY;
					nxt_busy_cnt = BUSY_W'(FLASH_CYCLES - 64'd1);
				end else if (ee_commit) begin
					nxt_state    = PPP_BUSY;
					nxt_busy_cnt = BUSY_W'(EEPROM_CYCLES - 64'd1);
				end else if (chip_erase) begin
					nxt_state    = PPP_BUSY;
					nxt_busy_cnt = BUSY_W'(ERASE_CYCLES - 64'd1);
				end else if (fuse_write || lock_write) begin
					nxt_state    = PPP_BUSY;
					nxt_busy_cnt = BUSY_W'(FUSE_CYCLES - 64'd1);
				end
			end
			PPP_BUSY: begin
				if (clk_en) begin
					if (busy_cnt_ff == '0) begin
						nxt_state = PPP_READY;
					end else begin
						nxt_busy_cnt = busy_cnt_ff - 1'b1;
					end
				end
			end
			default: begin
				nxt_state = PPP_READY;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fuse_lo_ff  <= FUSE_LO_RST;
			fuse_hi_ff  <= FUSE_HI_RST;
			fuse_ext_ff <= FUSE_EXT_RST;
			lock_ff     <= LOCK_RST;
			state_ff    <= PPP_READY;
			busy_cnt_ff <= '0;
		end else begin
			fuse_lo_ff  <= nxt_fuse_lo;
			fuse_hi_ff  <= nxt_fuse_hi;
			fuse_ext_ff <= nxt_fuse_ext;
			lock_ff     <= nxt_lock;
			state_ff    <= nxt_state;
			busy_cnt_ff <= nxt_busy_cnt;
		end
	end

	// Read path: data chosen by the command and selects, then registered.
	// The bus is driven only while read_drive_n is low; a programmer that
	// drives the bus with it low will collide with us.
	logic [7:0] rd_mux;
	logic [7:0] data_out_ff, nxt_data_out;
	logic       data_oe_ff, nxt_data_oe;

	always_comb begin
		rd_mux = ERASED_BYTE;
		case (cmd_ff)
			CMD_RD_FLASH: begin
				rd_mux = s_bsa ? flash_rd[15:8] : flash_rd[7:0]; // see R7 R8
			end
			CMD_RD_EEPROM: begin
				if (!s_bsa) begin
					rd_mux = ee_rd; // see R9
				end
			end
			CMD_RD_FUSE: begin
				case (s_sel) // see R16
					SEL_FUSE_LO:  rd_mux = fuse_lo_ff;
					SEL_FUSE_HI:  rd_mux = fuse_hi_ff;
					SEL_FUSE_EXT: rd_mux = fuse_ext_ff;
					SEL_LOCK:     rd_mux = lock_ff;
					default:      rd_mux = ERASED_BYTE;
				endcase
			end
			CMD_RD_ID: begin
				if (s_bsa) begin
					if (addr_lo_ff == CAL_ADDR) begin
						rd_mux = CAL_BYTE; // see R18
					end
				end else if (addr_lo_ff <= ID_ADDR_MAX) begin
					case (addr_lo_ff[1:0]) // see R17
						2'h0:    rd_mux = ID_BYTE0;
						2'h1:    rd_mux = ID_BYTE1;
						default: rd_mux = ID_BYTE2;
					endcase
				end
			end
			default: begin
				rd_mux = ERASED_BYTE;
			end
		endcase
		nxt_data_out = clk_en ? rd_mux : data_out_ff;
		nxt_data_oe  = clk_en ? !s_read_n : data_oe_ff; // see R21 R23
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_out_ff <= ERASED_BYTE;
			data_oe_ff  <= 1'b0;
		end else begin
			data_out_ff <= nxt_data_out;
			data_oe_ff  <= nxt_data_oe;
		end
	end

	// Outputs
	assign data_out        = data_out_ff;
	assign data_oe         = data_oe_ff;
	assign ready_busy_flag = ready; // see R20
	assign fuse_low        = fuse_lo_ff;
	assign fuse_high       = fuse_hi_ff;
	assign fuse_ext        = fuse_ext_ff;
	assign lock_bits       = lock_ff;
endmodule

// ===== src/ppp_pkg.sv
// Constants shared by the parallel programming port: pin field positions,
// action and command encodings, lock layout, erased values and busy times.
// Assumes a 250 MHz ref_clk; busy times are turned into cycle counts here.
package ppp_pkg;

	// Core clock rate in MHz, used to turn nanoseconds into cycles
	localparam longint unsigned CLK_MHZ = 64'd250;

	// Positions of the pins inside the synchronised pin vector
	localparam int PIN_W      = 16;
	localparam int PIN_DATA   = 0;
	localparam int PIN_READ_N = 8;
	localparam int PIN_PROG_N = 9;
	localparam int PIN_LATCH  = 10;
	localparam int PIN_BSB    = 11;
	localparam int PIN_BSA    = 12;
	localparam int PIN_ACT_LO = 13;
	localparam int PIN_ACT_HI = 14;
	localparam int PIN_LOAD   = 15;
	localparam logic [15:0] PIN_IDLE = 16'h0300; // Reset pin levels: read_drive_n and program_strobe_n high, rest low

	// Action select coding, {action_select_hi, action_select_lo}
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;

	// Command bytes
	localparam logic [7:0] CMD_NOP        = 8'h00;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
	localparam logic [7:0] CMD_RD_ID      = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;

	// Byte select coding {byte_select_b, byte_select_a}
	localparam logic [1:0] SEL_FUSE_LO  = 2'h0;
	localparam logic [1:0] SEL_LOCK     = 2'h1;
	localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
	localparam logic [1:0] SEL_FUSE_HI  = 2'h3;

	// Identification addresses
	localparam logic [7:0] ID_ADDR_MAX = 8'h02;
	localparam logic [7:0] CAL_ADDR    = 8'h00;

	// Lock byte layout: two basic bits, four boot bits, two unused
	localparam logic [7:0] LOCK_BASIC_MASK = 8'h03;
	localparam logic [7:0] LOCK_BOOT_MASK  = 8'h3C;
	localparam logic [7:0] LOCK_UNUSED     = 8'hC0;

	// Reset and erased values
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	localparam logic [7:0] FUSE_LO_RST  = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST  = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] LOCK_RST     = 8'hFF;

	// Self-timed operation times in ns, and least cycle counts (rounded up)
	localparam longint unsigned T_FLASH_NS  = 64'd4500000;
	localparam longint unsigned T_EEPROM_NS = 64'd3600000;
	localparam longint unsigned T_ERASE_NS  = 64'd9000000;
	localparam longint unsigned T_FUSE_NS   = 64'd4500000;
	localparam longint unsigned CYC_FLASH  = (T_FLASH_NS * CLK_MHZ + 64'd999) / 64'd1000;
	localparam longint unsigned CYC_EEPROM = (T_EEPROM_NS * CLK_MHZ + 64'd999) / 64'd1000;
	localparam longint unsigned CYC_ERASE  = (T_ERASE_NS * CLK_MHZ + 64'd999) / 64'd1000;
	localparam longint unsigned CYC_FUSE   = (T_FUSE_NS * CLK_MHZ + 64'd999) / 64'd1000;
	localparam int BUSY_W = 22;

	// Operation state
	typedef enum logic {
		PPP_READY,
		PPP_BUSY
	} ppp_state_type;

endpackage

// ===== src/ppp_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes every bit is asynchronous to ref_clk; bits are not coherent.
`timescale 1ns/10ps
module ppp_sync #(
	parameter int W = 16,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock, reset, enable
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	// Pins and their synchronised copy
	input  wire logic [W-1:0] pin_raw,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// Each bit passes two flops; the first is read by the second only
	generate
		for (genvar g = 0; g < W; g++) begin : g_bit
			always_comb begin
				nxt_meta[g] = clk_en ? pin_raw[g] : meta_ff[g];
				nxt_sync[g] = clk_en ? meta_ff[g] : sync_ff[g];
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					meta_ff[g] <= RST_VAL[g];
					sync_ff[g] <= RST_VAL[g];
				end else begin
					meta_ff[g] <= nxt_meta[g];
					sync_ff[g] <= nxt_sync[g];
				end
			end
		end
	endgenerate

	assign pin_sync = sync_ff;
endmodule

// ===== src/ppp_page_mem.sv
// Paged nonvolatile array model: page buffer plus array, both in flops.
// Assumes the caller issues commit and erase as one-cycle pulses.
`timescale 1ns/10ps
module ppp_page_mem #(
	parameter int DW = 16,
	parameter int AW = 8,
	parameter int PW = 4
) (
	// Clock, reset, enable
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            clk_en,
	// Page buffer load
	input  wire logic            buf_we,
	input  wire logic [PW-1:0]   buf_idx,
	input  wire logic [DW-1:0]   buf_data,
	// Page commit and full erase
	input  wire logic            commit,
	input  wire logic [AW-PW-1:0] commit_page,
	input  wire logic            erase,
	// Read port
	input  wire logic [AW-1:0]   rd_addr,
	output logic      [DW-1:0]   rd_data
);
	localparam int DEPTH = 1 << AW;
	localparam int PSIZE = 1 << PW;

	logic [DW-1:0] mem_ff   [DEPTH];
	logic [DW-1:0] nxt_mem  [DEPTH];
	logic [DW-1:0] buf_ff   [PSIZE];
	logic [DW-1:0] nxt_buf  [PSIZE];

	// Array entries: erase wins, else a commit copies the buffer into its page
	generate
		for (genvar g = 0; g < DEPTH; g++) begin : g_mem
			localparam logic [AW-PW-1:0] PG = (AW-PW)'(g / PSIZE);
			always_comb begin
				if (clk_en && erase) begin
					nxt_mem[g] = {DW{1'b1}};
				end else if (clk_en && commit && commit_page == PG) begin
					nxt_mem[g] = buf_ff[g % PSIZE];
				end else begin
					nxt_mem[g] = mem_ff[g];
				end
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					mem_ff[g] <= {DW{1'b1}};
				end else begin
					mem_ff[g] <= nxt_mem[g];
				end
			end
		end

		// Buffer entries return to erased after a commit so stale words never repeat
		for (genvar b = 0; b < PSIZE; b++) begin : g_buf
			always_comb begin
				if (clk_en && (commit || erase)) begin
					nxt_buf[b] = {DW{1'b1}};
				end else if (clk_en && buf_we && buf_idx == PW'(b)) begin
					nxt_buf[b] = buf_data;
				end else begin
					nxt_buf[b] = buf_ff[b];
				end
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					buf_ff[b] <= {DW{1'b1}};
				end else begin
					buf_ff[b] <= nxt_buf[b];
				end
			end
		end
	endgenerate

	assign rd_data = mem_ff[rd_addr];
endmodule

// ===== bench/ppp_port_monitor.sv
// Checker for the parallel programming port: pin to output timing.
// Assumes each pin level is held at least four ref_clk cycles.
`timescale 1ns/10ps
module ppp_port_chk (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// Programmer pins
	input wire logic       program_strobe_n,
	input wire logic       read_drive_n,
	// Device outputs
	input wire logic       data_oe,
	input wire logic       ready_busy_flag,
	input wire logic [7:0] fuse_low,
	input wire logic [7:0] fuse_high,
	input wire logic [7:0] fuse_ext,
	input wire logic [7:0] lock_bits
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Busy stays low a while, then must come back within a bound
	sequence busy_run;
		(!ready_busy_flag)[*8] ##[1:40] ready_busy_flag;
	endsequence

	oe_on_a: assert property ($fell(read_drive_n) |-> ##[1:5] data_oe)
		else $error("bus not driven after read request");
	oe_off_a: assert property ($rose(read_drive_n) |-> ##[1:5] !data_oe)
		else $error("bus still driven after read release");
	oe_idle_a: assert property (read_drive_n[*6] |-> !data_oe)
		else $error("bus driven without read request");
	busy_cause_a: assert property ($fell(ready_busy_flag) |->
		!program_strobe_n && $past(program_strobe_n, 8))
		else $error("busy without program strobe");
	busy_len_a: assert property ($fell(ready_busy_flag) |-> busy_run)
		else $error("busy window wrong length");
	lock_keep_a: assert property ($changed(lock_bits) |->
		(lock_bits & ~$past(lock_bits)) == 8'h00 || lock_bits == 8'hFF)
		else $error("lock bit returned to unprogrammed");
	boot_hold_a: assert property ($past(lock_bits[1:0]) == 2'h0 |->
		lock_bits[5:2] == $past(lock_bits[5:2]) || lock_bits == 8'hFF)
		else $error("boot lock bits changed in mode 3");
	nv_busy_a: assert property (
		$changed({fuse_low, fuse_high, fuse_ext, lock_bits}) |->
		(##[0:2] !ready_busy_flag) or !$past(ready_busy_flag))
		else $error("fuse or lock changed outside a write");
endmodule
bind ppp_port ppp_port_chk ppp_port_chk_inst (.ref_clk(ref_clk), .rst(rst),
	.program_strobe_n(program_strobe_n), .read_drive_n(read_drive_n), .data_oe(data_oe),
	.ready_busy_flag(ready_busy_flag), .fuse_low(fuse_low), .fuse_high(fuse_high),
	.fuse_ext(fuse_ext), .lock_bits(lock_bits));

// ===== bench/ppp_prog_model.sv
// Programmer side of the shared data bus, with the wire level resolved.
// Assumes the bench raises drive and read requests at falling edges.
`timescale 1ns/10ps
module ppp_prog_model (
	// Clock
	input wire logic       ref_clk,
	// Programmer requests
	input wire logic       drive_req,
	input wire logic       read_req,
	input wire logic [7:0] drive_val,
	// Device side of the bus
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	// Pin levels
	output logic           read_drive_n,
	output logic     [7:0] data_in
);
	logic [7:0] last_val = 8'h00;

	// Never ask for a read while driving, so the bus has one owner
	assign read_drive_n = !read_req || drive_req;
	// A released bus keeps changing, so stale data cannot pass for a read
	always_comb begin
		if (data_oe)
			data_in = data_out;
		else if (drive_req)
			data_in = drive_val;
		else
			data_in = ~last_val;
	end
	// Remember the last level seen on the wire
	always_ff @(posedge ref_clk) begin
		last_val <= data_in;
	end
endmodule

// ===== bench/ppp_port_tb.sv
// Testbench for the parallel programming port, driven pin by pin.
// Assumes programming mode is entered; busy times shortened to C cycles.
`timescale 1ns/10ps
module ppp_port_tb;
	import ppp_pkg::*;
	localparam longint unsigned C = 20;
	localparam logic [23:0] ID_V  = 24'h636261; // arbitrary identification value
	localparam logic [7:0]  CAL_V = 8'h47;      // arbitrary calibration value
	logic       ref_clk, rst, load_strobe, act_hi, act_lo, bsa, bsb, latch, prog_n;
	logic       drive_req, read_req, data_oe, ready_busy_flag, read_drive_n;
	logic [7:0] drive_val, data_in, data_out, fuse_low, fuse_high, fuse_ext, lock_bits;
	logic [7:0] a, d, h, v, e;
	logic [7:0] fl [3];
	int         err_count, tests_run, seed;

	ppp_port #(.FLASH_CYCLES(C), .EEPROM_CYCLES(C), .ERASE_CYCLES(C), .FUSE_CYCLES(C),
		.ID_BYTE0(ID_V[7:0]), .ID_BYTE1(ID_V[15:8]), .ID_BYTE2(ID_V[23:16]),
		.CAL_BYTE(CAL_V)) ppp_port_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
		.load_strobe(load_strobe), .action_select_hi(act_hi), .action_select_lo(act_lo),
		.byte_select_a(bsa), .byte_select_b(bsb), .page_latch_strobe(latch),
		.program_strobe_n(prog_n), .read_drive_n(read_drive_n), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
		.fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext),
		.lock_bits(lock_bits));
	ppp_prog_model ppp_prog_model_inst (.ref_clk(ref_clk), .drive_req(drive_req),
		.read_req(read_req), .drive_val(drive_val), .data_out(data_out),
		.data_oe(data_oe), .read_drive_n(read_drive_n), .data_in(data_in));

	// Free-running 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One load pulse; pins settle well before and after the edge
	task automatic ld(input logic [1:0] act, input logic sa, input logic [7:0] val);
		{act_hi, act_lo} = act;
		bsa = sa;
		drive_val = val;
		drive_req = 1'b1;
		step(5);
		load_strobe = 1'b1;
		step(5);
		load_strobe = 1'b0;
		step(5);
		drive_req = 1'b0;
		{act_hi, act_lo} = ACT_IDLE;
	endtask
	task automatic pulse_latch;
		latch = 1'b1;
		step(5);
		latch = 1'b0;
		step(5);
	endtask
	// Program pulse, then a bounded wait for ready; selects go back low
	task automatic prog(input logic sb, input logic sa);
		int n;
		{bsb, bsa} = {sb, sa};
		step(5);
		prog_n = 1'b0;
		step(10);
		check({7'h00, ready_busy_flag}, 8'h00);
		prog_n = 1'b1;
		n = 0;
		while (ready_busy_flag !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		check({7'h00, ready_busy_flag}, 8'h01);
		{bsb, bsa} = 2'h0;
		step(5);
	endtask
	task automatic rd(input logic sb, input logic sa, input logic [7:0] exp);
		{bsb, bsa} = {sb, sa};
		read_req = 1'b1;
		step(6);
		check(data_in, exp);
		read_req = 1'b0;
		step(6);
	endtask
	// Lock write: zeros stick, boot bits frozen in mode 3, top bits stay set
	function automatic logic [7:0] lock_next(input logic [7:0] cur, input logic [7:0] w);
		logic [7:0] keep;
		keep = (cur[1:0] == 2'h0) ? LOCK_BOOT_MASK : 8'h00;
		return (cur & (w | keep)) | LOCK_UNUSED;
	endfunction
	task automatic test_done;
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 32'h0253;
		err_count = 0;
		tests_run = 0;
		rst = 1'b1;
		{load_strobe, latch, bsa, bsb, drive_req, read_req} = 6'h00;
		{act_hi, act_lo} = ACT_IDLE;
		prog_n = 1'b1;
		drive_val = 8'h00;
		step(5);
		rst = 1'b0;
		step(5);
		repeat (2) begin
			a = 8'($random(seed));
			d = 8'($random(seed));
			h = 8'($random(seed));
			ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
			ld(ACT_ADDR, 1'b0, a);
			ld(ACT_DATA, 1'b0, d);
			ld(ACT_DATA, 1'b1, h);
			pulse_latch();
			ld(ACT_ADDR, 1'b1, 8'h00);
			prog(1'b0, 1'b0);
			ld(ACT_CMD, 1'b0, CMD_NOP);
			ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
			ld(ACT_ADDR, 1'b1, 8'h00);
			ld(ACT_ADDR, 1'b0, a);
			rd(1'b0, 1'b0, d);
			rd(1'b0, 1'b1, h);
		end
		$display("flash test done");
		a = 8'($random(seed)) & 8'h3F;
		ld(ACT_CMD, 1'b0, CMD_WR_EEPROM);
		ld(ACT_ADDR, 1'b1, 8'h00);
		ld(ACT_ADDR, 1'b0, a);
		ld(ACT_DATA, 1'b0, d);
		pulse_latch();
		prog(1'b0, 1'b0);
		ld(ACT_CMD, 1'b0, CMD_RD_EEPROM);
		rd(1'b0, 1'b0, d);
		$display("eeprom test done");
		for (int i = 0; i < 3; i++) begin
			fl[i] = 8'($random(seed));
			ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
			ld(ACT_DATA, 1'b0, fl[i]);
			prog(i[1], i[0]);
		end
		check(fuse_high, fl[1]);
		check(fuse_low, fl[0]);
		check(fuse_ext, fl[2]);
		ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
		rd(1'b0, 1'b0, fl[0]);
		rd(1'b1, 1'b1, fl[1]);
		rd(1'b1, 1'b0, fl[2]);
		$display("fuse test done");
		e = LOCK_RST;
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? (8'($random(seed)) & 8'hFC) : ((i == 1) ? 8'h00 : 8'hFF);
			ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
			ld(ACT_DATA, 1'b0, v);
			prog(1'b0, 1'b0);
			e = lock_next(e, v);
			check(lock_bits, e);
		end
		ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
		rd(1'b0, 1'b1, e);
		ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		prog(1'b0, 1'b0);
		check(lock_bits, LOCK_RST);
		$display("lock test done");
		ld(ACT_CMD, 1'b0, CMD_RD_ID);
		for (int i = 0; i < 3; i++) begin
			ld(ACT_ADDR, 1'b0, 8'(i));
			rd(1'b0, 1'b0, ID_V[8*i +: 8]);
		end
		ld(ACT_ADDR, 1'b0, CAL_ADDR);
		rd(1'b0, 1'b1, CAL_V);
		$display("id test done");
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		err_count++;
		test_done();
	end
endmodule
